/* src/sdr_params.svh */
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH

// ============================================================
// Register byte offsets
`define SDR_OFF_CMD      8'h00
`define SDR_OFF_STATUS   8'h04
`define SDR_OFF_SEL      8'h08
`define SDR_OFF_DATA     8'h0c
`define SDR_OFF_MODE     8'h10
`define SDR_OFF_PTRS     8'h14
`define SDR_OFF_IO       8'h18
`define SDR_OFF_SETTLE   8'h1c
`define SDR_OFF_ROWS     8'h20
`define SDR_OFF_BUSCFG   8'h24

// ============================================================
// Field positions
`define SDR_CMD_OP_BIT   8
`define SDR_ST_BUSY      0
`define SDR_ST_ERR       1
`define SDR_ST_BLANK     2

// ============================================================
// Setup memory geometry and command limits
`define SDR_XP_W         32
`define SDR_TOP_LOC      7'd100
`define SDR_FIRST_LOC    7'd1
`define SDR_LIVE_LOC     7'd0

// ============================================================
// Factory defaults
`define SDR_DEF_EDGE     1'b0
`define SDR_DEF_RDYPOL   1'b0
`define SDR_DEF_EDIT     7'd0
`define SDR_DEF_HSK      2'h0
`define SDR_DEF_SRQMASK  8'h00
`define SDR_DEF_DIGOUT   8'h00
`define SDR_DEF_SETTLE   16'h0000
`define SDR_DEF_TRIGSRC  4'h7
`define SDR_DEF_ROWS     8'h00
`define SDR_DEF_TERM     3'h0
`define SDR_DEF_ACTIVE   7'd0
`define SDR_DEF_STORED   7'd1
`define SDR_DEF_BUSADDR  5'h12
`define SDR_DEF_MASTER   1'b1

`endif

/* src/sdr_pkg.sv */
package sdr_pkg;

  // ============================================================
  // Types
  typedef enum logic [1:0]
  {
    SDR_IDLE,
    SDR_SHIFT,
    SDR_CLRTOP,
    SDR_RESTORE
  } sdr_state_e;

  typedef logic [6:0] sdr_loc_t;

endpackage

/* src/sdr_setup_ctrl.sv */
// What this block does
// - Delete accepts only locations 1 through 100; live location 0 rejected.
// - Delete n moves setups n+1..100 down one place, ascending order.
// - After the shift, top location 100 is cleared completely.
// - Display is blanked for the whole delete and restored afterwards.
// - Deleting location 100 skips the shift and only clears location 100.
// - Restore accepts only parameter zero and clears all stored setups.
// - Restore clears make-before-break and break-before-make row selections.
// - Restore opens all relays, active index 000, stored index 001.
// - Restore selects falling-edge external trigger.
// - Restore sets matrix-settled output to negative-true polarity.
// - Restore points the edit pointer at live location zero.
// - Restore selects EOI on last byte with hold-off until ready.
// - Restore clears the service-request mask.
// - Restore drives all eight digital outputs low.
// - Restore sets additional settling time to zero milliseconds.
// - Restore selects external trigger pulse as trigger source.
// - Restore sets both row selection masks to all zeros.
// - Restore selects carriage return then line feed terminator.
// - Restore leaves bus address and master/slave setting untouched.
// - Out-of-range parameter sets the bad option error, not executed.
//
// The address map and the address-and-strobe port were left to the implementer.
`include "sdr_params.svh"

module sdr_setup_ctrl
  import sdr_pkg::*;
(
  input  wire logic                 clk,            // 250 MHz clock
  input  wire logic                 resetn,         // Async reset, low
  input  wire logic [7:0]           addr,           // Register byte address
  input  wire logic [31:0]          wdata,          // Write data
  input  wire logic                 wr,             // Write strobe
  input  wire logic                 rd,             // Read strobe
  output logic      [31:0]          rdata,          // Read data, next cycle
  output logic                      busy,           // Operation running
  output logic                      displayBlank,   // Front display off
  output logic      [`SDR_XP_W-1:0] relayDrive,     // Live crosspoints
  output logic      [7:0]           digitalOut,     // Digital output port
  output logic                      trigFalling,    // Trigger edge select
  output logic      [15:0]          settleMs        // Extra settling time
);

  // ============================================================
  // Storage and state
  logic [`SDR_XP_W-1:0] setupMem_r [0:100];
  sdr_state_e           state_r;
  sdr_loc_t             idx_r;
  sdr_loc_t             sel_r;
  logic                 badOptionError_r;
  logic                 blank_r;
  logic                 trigEdge_r;
  logic                 readyPol_r;
  sdr_loc_t             editPtr_r;
  logic [1:0]           handshake_r;
  logic [7:0]           srqMask_r;
  logic [7:0]           digOut_r;
  logic [15:0]          settle_r;
  logic [3:0]           trigSrc_r;
  logic [7:0]           mbbRows_r;
  logic [7:0]           bbmRows_r;
  logic [2:0]           term_r;
  sdr_loc_t             activeIdx_r;
  sdr_loc_t             storedIdx_r;
  logic [4:0]           busAddr_r;
  logic                 master_r;
  logic [31:0]          rdata_r;

  logic                 cmdWr;
  logic                 cmdOp;
  sdr_loc_t             cmdParam;
  logic                 cmdOk;
  logic                 startDel;
  logic                 startRst;
  logic                 restoreNow;
  logic                 cfgWr;
  // ============================================================
  // Option check shared by the start and error paths
  function automatic logic optionOk
  (
    input logic       op,
    input logic [7:0] param
  );
    if (op)
    begin
      return (param == 8'h00);
    end
    return (param >= {1'b0, `SDR_FIRST_LOC}) && (param <= {1'b0, `SDR_TOP_LOC});
  endfunction

  // ============================================================
  // Command decode
  // Commands arriving while busy are dropped so memory is never seen half done
  assign cmdWr      = wr && (addr == `SDR_OFF_CMD);
  assign cmdOp      = wdata[`SDR_CMD_OP_BIT];
  assign cmdParam   = wdata[6:0];
  assign cmdOk      = optionOk(cmdOp, wdata[7:0]);
  assign startDel   = cmdWr && (state_r == SDR_IDLE) && cmdOk && !cmdOp;
  assign startRst   = cmdWr && (state_r == SDR_IDLE) && cmdOk && cmdOp;
  assign restoreNow = (state_r == SDR_RESTORE);
  assign cfgWr      = wr && (state_r == SDR_IDLE);

  // ============================================================
  // Sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= SDR_IDLE;
      idx_r   <= `SDR_LIVE_LOC;
    end
    else
    begin
      unique case (state_r)
        SDR_IDLE:
        begin
          if (startDel)
          begin
            idx_r <= cmdParam;
            if (cmdParam == `SDR_TOP_LOC)
            begin
              state_r <= SDR_CLRTOP;
            end
            else
            begin
              state_r <= SDR_SHIFT;
            end
          end
          else if (startRst)
          begin
            state_r <= SDR_RESTORE;
          end
        end
        SDR_SHIFT:
        begin
          // One location per cycle, lowest first
          idx_r <= idx_r + 7'd1;
          if (idx_r == `SDR_TOP_LOC - 7'd1)
          begin
            state_r <= SDR_CLRTOP;
          end
        end
        SDR_CLRTOP, SDR_RESTORE:
        begin
          state_r <= SDR_IDLE;
        end
      endcase
    end
  end
  // ============================================================
  // Display blanking, registered so it covers every delete cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      blank_r <= 1'b0;
    end
    else if (startDel)
    begin
      blank_r <= 1'b1;
    end
    else if (state_r == SDR_CLRTOP)
    begin
      blank_r <= 1'b0;
    end
  end
  // ============================================================
  // Error flag: a new bad option wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      badOptionError_r <= 1'b0;
    end
    else if (cmdWr && !cmdOk)
    begin
      badOptionError_r <= 1'b1;
    end
    else if (wr && (addr == `SDR_OFF_STATUS) && wdata[`SDR_ST_ERR])
    begin
      badOptionError_r <= 1'b0;
    end
  end

  // ============================================================
  // Setup memory; location 0 is the live relay state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i <= 100; i++)
      begin
        setupMem_r[i] <= '0;
      end
    end
    else
    begin
      unique case (state_r)
        SDR_SHIFT:
        begin
          setupMem_r[idx_r] <= setupMem_r[idx_r + 7'd1];
        end
        SDR_CLRTOP:
        begin
          setupMem_r[`SDR_TOP_LOC] <= '0;
        end
        SDR_RESTORE:
        begin
          // Stored setups and the live relays are opened together
          for (int i = 0; i <= 100; i++)
          begin
            setupMem_r[i] <= '0;
          end
        end
        SDR_IDLE:
        begin
          if (cfgWr && (addr == `SDR_OFF_DATA) && (sel_r <= `SDR_TOP_LOC))
          begin
            setupMem_r[sel_r] <= wdata[`SDR_XP_W-1:0];
          end
        end
      endcase
    end
  end
  // ============================================================
  // Memory access index
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_r <= `SDR_LIVE_LOC;
    end
    else if (wr && (addr == `SDR_OFF_SEL))
    begin
      sel_r <= wdata[6:0];
    end
  end
  // ============================================================
  // Trigger, polarity, handshake, terminator modes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trigEdge_r  <= `SDR_DEF_EDGE;
      readyPol_r  <= `SDR_DEF_RDYPOL;
      handshake_r <= `SDR_DEF_HSK;
      trigSrc_r   <= `SDR_DEF_TRIGSRC;
      term_r      <= `SDR_DEF_TERM;
    end
    else if (restoreNow)
    begin
      trigEdge_r  <= `SDR_DEF_EDGE;
      readyPol_r  <= `SDR_DEF_RDYPOL;
      handshake_r <= `SDR_DEF_HSK;
      trigSrc_r   <= `SDR_DEF_TRIGSRC;
      term_r      <= `SDR_DEF_TERM;
    end
    else if (cfgWr && (addr == `SDR_OFF_MODE))
    begin
      trigEdge_r  <= wdata[0];
      readyPol_r  <= wdata[1];
      handshake_r <= wdata[3:2];
      trigSrc_r   <= wdata[7:4];
      term_r      <= wdata[10:8];
    end
  end
  // ============================================================
  // Edit, active and stored pointers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      editPtr_r   <= `SDR_DEF_EDIT;
      activeIdx_r <= `SDR_DEF_ACTIVE;
      storedIdx_r <= `SDR_DEF_STORED;
    end
    else if (restoreNow)
    begin
      editPtr_r   <= `SDR_DEF_EDIT;
      activeIdx_r <= `SDR_DEF_ACTIVE;
      storedIdx_r <= `SDR_DEF_STORED;
    end
    else if (cfgWr && (addr == `SDR_OFF_PTRS))
    begin
      editPtr_r   <= wdata[6:0];
      activeIdx_r <= wdata[14:8];
      storedIdx_r <= wdata[22:16];
    end
  end
  // ============================================================
  // Service-request mask and digital outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      srqMask_r <= `SDR_DEF_SRQMASK;
      digOut_r  <= `SDR_DEF_DIGOUT;
    end
    else if (restoreNow)
    begin
      srqMask_r <= `SDR_DEF_SRQMASK;
      digOut_r  <= `SDR_DEF_DIGOUT;
    end
    else if (cfgWr && (addr == `SDR_OFF_IO))
    begin
      srqMask_r <= wdata[7:0];
      digOut_r  <= wdata[15:8];
    end
  end
  // ============================================================
  // User settling time in milliseconds
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      settle_r <= `SDR_DEF_SETTLE;
    end
    else if (restoreNow)
    begin
      settle_r <= `SDR_DEF_SETTLE;
    end
    else if (cfgWr && (addr == `SDR_OFF_SETTLE))
    begin
      settle_r <= wdata[15:0];
    end
  end
  // ============================================================
  // Make-before-break and break-before-make row masks
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mbbRows_r <= `SDR_DEF_ROWS;
      bbmRows_r <= `SDR_DEF_ROWS;
    end
    else if (restoreNow)
    begin
      mbbRows_r <= `SDR_DEF_ROWS;
      bbmRows_r <= `SDR_DEF_ROWS;
    end
    else if (cfgWr && (addr == `SDR_OFF_ROWS))
    begin
      mbbRows_r <= wdata[7:0];
      bbmRows_r <= wdata[15:8];
    end
  end
  // ============================================================
  // Bus address and master flag; restore deliberately leaves them alone
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busAddr_r <= `SDR_DEF_BUSADDR;
      master_r  <= `SDR_DEF_MASTER;
    end
    else if (cfgWr && (addr == `SDR_OFF_BUSCFG))
    begin
      busAddr_r <= wdata[4:0];
      master_r  <= wdata[8];
    end
  end
  // ============================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_r <= '0;
    end
    else if (rd)
    begin
      unique case (addr)
        `SDR_OFF_STATUS: rdata_r <= {29'h0, blank_r, badOptionError_r, busy};
        `SDR_OFF_SEL:    rdata_r <= {25'h0, sel_r};
        `SDR_OFF_DATA:   rdata_r <= (sel_r <= `SDR_TOP_LOC) ? setupMem_r[sel_r] : '0;
        `SDR_OFF_MODE:   rdata_r <= {21'h0, term_r, trigSrc_r, handshake_r, readyPol_r, trigEdge_r};
        `SDR_OFF_PTRS:   rdata_r <= {9'h0, storedIdx_r, 1'b0, activeIdx_r, 1'b0, editPtr_r};
        `SDR_OFF_IO:     rdata_r <= {16'h0, digOut_r, srqMask_r};
        `SDR_OFF_SETTLE: rdata_r <= {16'h0, settle_r};
        `SDR_OFF_ROWS:   rdata_r <= {16'h0, bbmRows_r, mbbRows_r};
        `SDR_OFF_BUSCFG: rdata_r <= {23'h0, master_r, 3'h0, busAddr_r};
        default:         rdata_r <= '0;
      endcase
    end
    else
    begin
      rdata_r <= '0;
    end
  end
  // ============================================================
  // Outputs
  assign rdata        = rdata_r;
  assign busy         = (state_r != SDR_IDLE);
  assign displayBlank = blank_r;
  assign relayDrive   = setupMem_r[0];
  assign digitalOut   = digOut_r;
  assign trigFalling  = !trigEdge_r;
  assign settleMs     = settle_r;
endmodule

/* bench/sdr_bus_ctrl_model.sv */
// ============================================================
// Bus controller model: plain register port master
module sdr_bus_ctrl_model
(
  input  wire logic        clk,    // Bench clock
  output logic      [7:0]  addr,   // Register address
  output logic      [31:0] wdata,  // Write data
  output logic             wr,     // Write strobe
  output logic             rd,     // Read strobe
  input  wire logic [31:0] rdata   // Read data
);
  // Idle bus at time zero
  initial
  begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One write cycle; address and data are inverted afterwards so a stale value never helps
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask

  // One read cycle; data is taken in the single cycle it stands
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask

  // Poll busy so no command overlaps a running operation
  task automatic waitIdle();
    logic [31:0] st;
    // No limit here: a hang runs into the bench timeout, which counts as a failure
    do
    begin
      rdReg(8'h04, st);
    end while (st[0] !== 1'b0);
  endtask

  // Command word: op in bit 8, parameter in the low byte
  task automatic runCmd(input logic op, input logic [7:0] prm);
    wrReg(8'h00, {23'h0, op, prm});
    waitIdle();
  endtask
endmodule

/* bench/sdr_setup_ctrl_properties.sv */
`include "sdr_params.svh"

// ============================================================
// Port-level checker
module sdr_setup_ctrl_properties
(
  input wire logic                 clk,          // Clock
  input wire logic                 resetn,       // Async reset, low
  input wire logic [7:0]           addr,         // Address
  input wire logic [31:0]          wdata,        // Write data
  input wire logic                 wr,           // Write strobe
  input wire logic                 rd,           // Read strobe
  input wire logic [31:0]          rdata,        // Read data
  input wire logic                 busy,         // Operation running
  input wire logic                 displayBlank, // Display off
  input wire logic [`SDR_XP_W-1:0] relayDrive,   // Live crosspoints
  input wire logic [7:0]           digitalOut,   // Digital outputs
  input wire logic                 trigFalling,  // Trigger edge
  input wire logic [15:0]          settleMs      // Settling time
);
  logic       cmdWr;
  logic       delOk;
  logic       resOk;
  logic [7:0] busyCnt_r;
  logic [7:0] expLen_r;

  // Accepted commands as seen on the bus
  assign cmdWr = wr && addr == 8'h00 && !busy;
  assign delOk = cmdWr && !wdata[8] && wdata[7:0] >= 8'h01 && wdata[7:0] <= 8'h64;
  assign resOk = cmdWr && wdata[8] && wdata[7:0] == 8'h00;

  // Busy length counter; ties the whole shift span to the parameter, too long for a repetition
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      busyCnt_r <= 8'h00;
      expLen_r  <= 8'h00;
    end
    else if (delOk || resOk)
    begin
      busyCnt_r <= 8'h00;
      expLen_r  <= resOk ? 8'h01 : 8'h65 - wdata[7:0];
    end
    else if (busy)
      busyCnt_r <= busyCnt_r + 8'h01;

  // ============================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rdata_one_cycle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside its cycle");
  a_delete_blanks: assert property (delOk |=> busy && displayBlank)
    else $error("delete did not start blanked");
  a_blank_only_busy: assert property (displayBlank |-> busy)
    else $error("display blank while idle");
  a_busy_span_length: assert property ($fell(busy) |-> busyCnt_r == expLen_r)
    else $error("operation length wrong");
  a_top_delete_short: assert property (delOk && wdata[7:0] == 8'h64 |=> busy ##1 !busy)
    else $error("top delete not one cycle");
  a_restore_defaults: assert property (resOk |=> busy && !displayBlank ##1
      !busy && relayDrive == 0 && digitalOut == 8'h00 && trigFalling && settleMs == 16'h0000)
    else $error("restore defaults wrong");
  a_bad_option_idle: assert property (cmdWr && !delOk && !resOk |=> !busy)
    else $error("bad option executed");
  a_delete_keeps_live: assert property (displayBlank |=> $stable(relayDrive))
    else $error("delete touched live setup");
  a_busy_refuses_io: assert property (displayBlank && wr && addr == 8'h18 |=> $stable(digitalOut))
    else $error("write accepted while busy");
endmodule

bind sdr_setup_ctrl sdr_setup_ctrl_properties prop_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .busy(busy), .displayBlank(displayBlank), .relayDrive(relayDrive),
  .digitalOut(digitalOut), .trigFalling(trigFalling), .settleMs(settleMs));

/* bench/tb_setup_delete_and_restore.sv */
// ============================================================
// Self-checking bench
module tb_setup_delete_and_restore;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        resetn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        busy;
  logic        displayBlank;
  logic [31:0] relayDrive;
  logic [7:0]  digitalOut;
  logic        trigFalling;
  logic [15:0] settleMs;
  logic [31:0] mem [0:100];
  logic [31:0] bc;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  int          delList [4] = '{100, 1, 0, 99};
  logic [8:0]  badList [5] = '{9'h000, 9'h065, 9'h0ff, 9'h101, 9'h164};

  sdr_setup_ctrl dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .busy(busy), .displayBlank(displayBlank), .relayDrive(relayDrive),
    .digitalOut(digitalOut), .trigFalling(trigFalling), .settleMs(settleMs));
  sdr_bus_ctrl_model bus (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  // Clock and hang guard; the run needs about 4300 cycles
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus.rdReg(a, d);
    chk(d, exp);
  endtask

  // Expected memory after deleting location n: shift down, then empty the top
  function automatic void delModel(input int n);
    for (int i = n; i < 100; i++)
      mem[i] = mem[i + 1];
    mem[100] = 32'h0;
  endfunction

  // Read back every stored location and the live one
  task automatic memChk();
    for (int i = 1; i <= 100; i++)
    begin
      bus.wrReg(8'h08, i);
      rdChk(8'h0c, mem[i]);
    end
    @(negedge clk);
    chk(relayDrive, mem[0]);
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    void'($urandom(49));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk({31'h0, trigFalling}, 32'h1);
    for (int i = 0; i <= 100; i++)
    begin
      mem[i] = $urandom;
      bus.wrReg(8'h08, i);
      bus.wrReg(8'h0c, mem[i]);
    end
    delList[2] = $urandom_range(98, 2);
    foreach (delList[k])
    begin
      bus.runCmd(1'b0, 8'(delList[k]));
      delModel(delList[k]);
      memChk();
    end
    // Out-of-range parameters raise the error and leave memory alone
    foreach (badList[k])
    begin
      bus.runCmd(badList[k][8], badList[k][7:0]);
      rdChk(8'h04, 32'h2);
      bus.wrReg(8'h04, 32'h2);
    end
    memChk();
    // Writes and a second command while a long delete runs are dropped
    bus.wrReg(8'h18, 32'h0000a500);
    bus.wrReg(8'h00, 32'h1);
    bus.wrReg(8'h18, 32'h00003c00);
    bus.wrReg(8'h00, 32'h5);
    bus.waitIdle();
    delModel(1);
    rdChk(8'h04, 32'h0);
    chk({24'h0, digitalOut}, 32'ha5);
    memChk();
    // Dirty every mode field, then restore
    bc = $urandom & 32'h11f;
    bus.wrReg(8'h10, 32'h7ff);
    bus.wrReg(8'h14, 32'h452321);
    bus.wrReg(8'h1c, 32'h1388);
    bus.wrReg(8'h20, 32'hffff);
    bus.wrReg(8'h24, bc);
    chk({15'h0, trigFalling, settleMs}, 32'h1388);
    bus.runCmd(1'b1, 8'h00);
    foreach (mem[i])
      mem[i] = 32'h0;
    memChk();
    rdChk(8'h10, 32'h70);
    rdChk(8'h14, 32'h10000);
    rdChk(8'h18, 32'h0);
    rdChk(8'h1c, 32'h0);
    rdChk(8'h20, 32'h0);
    rdChk(8'h24, bc);
    chk({15'h0, trigFalling, settleMs}, 32'h10000);
    end_of_test();
  end
endmodule
